/* File: shared/sbsr_map.svh */
/*
  Bit positions, widths and used-bit masks of the status reporting block.
  Assumes it is included by bare name from the package and design files.
*/
`ifndef SBSR_MAP_SVH
`define SBSR_MAP_SVH

`define STB_WIDTH                8
`define STD_WIDTH                8
`define LOCKIN_WIDTH             16
`define ERROR_WIDTH              8
`define QUERY_WIDTH              16

`define SB_STORAGE_IDLE          0
`define SB_COMMAND_IDLE          1
`define SB_ERROR_SUMMARY         2
`define SB_LOCKIN_SUMMARY        3
`define SB_MESSAGE_AVAILABLE     4
`define SB_STD_SUMMARY           5
`define SB_SERVICE_REQUEST       6
`define STB_REQUEST_MASK         8'h3F

`define STD_INPUT_QUEUE_OVERFLOW  0
`define STD_OUTPUT_QUEUE_OVERFLOW 2
`define STD_EXECUTION_ERROR       4
`define STD_ILLEGAL_COMMAND       5
`define STD_USER_ACTIVITY         6
`define STD_POWER_ON              7
`define STD_USED_MASK             8'hF5

`define LOCK_REFERENCE_UNLOCK     0
`define LOCK_REFERENCE_RANGE      1
`define LOCK_STORAGE_TRIGGERED    3
`define LOCK_SIGNAL_INPUT_OVL     4
`define LOCK_IF_AMPLIFIER_OVL     5
`define LOCK_FILTER_OVL           6
`define LOCK_REFERENCE_SHIFT      7
`define LOCK_CHANNEL_ONE_OVL      8
`define LOCK_CHANNEL_TWO_OVL      9
`define LOCK_AUX_INPUT_OVL        10
`define LOCK_RATIO_UNDERFLOW      11
`define LOCKIN_USED_MASK          16'h0FFB

`define ERR_BATTERY_BACKUP        1
`define ERR_RAM_TEST              2
`define ERR_LOGIC_ARRAY_TEST      3
`define ERR_ROM_TEST              4
`define ERR_FAST_TRANSFER_ABORT   5
`define ERR_DSP_TEST              6
`define ERR_MATH_FAULT            7
`define ERROR_USED_MASK           8'hFE

`endif

/* File: shared/sbsr_pkg.sv */
/*
  Types of the status reporting block: query and mask selectors, state structs.
  Assumes sbsr_map.svh is on the include path.
*/
`include "sbsr_map.svh"

package sbsr_pkg;

  typedef enum logic [2:0] {
    Q_STATUS_BYTE  = 3'h0,
    Q_STD_EVENT    = 3'h1,
    Q_LOCKIN       = 3'h2,
    Q_ERROR        = 3'h3,
    Q_POLL_ENABLE  = 3'h4,
    Q_STD_ENABLE   = 3'h5,
    Q_ERROR_ENABLE = 3'h6,
    Q_LOCK_ENABLE  = 3'h7
  } query_sel_t;

  typedef enum logic [1:0] {
    M_POLL_ENABLE  = 2'h0,
    M_STD_ENABLE   = 2'h1,
    M_ERROR_ENABLE = 2'h2,
    M_LOCK_ENABLE  = 2'h3
  } mask_sel_t;

  typedef struct packed {
    logic                       ready;
    logic [`STB_WIDTH-1:0]      poll_en;
    logic [`STD_WIDTH-1:0]      std_en;
    logic [`ERROR_WIDTH-1:0]    err_en;
    logic [`LOCKIN_WIDTH-1:0]   lock_en;
    logic                       query_valid;
    logic [`QUERY_WIDTH-1:0]    query_data;
    logic                       poll_valid;
    logic [`STB_WIDTH-1:0]      poll_byte;
    logic                       flush;
    logic [`STB_WIDTH-1:0]      status;
  } top_state_t;

  typedef struct packed {
    logic [`STB_WIDTH-1:0]      prev;
    logic                       pending;
  } srq_state_t;

endpackage : sbsr_pkg

/* File: design/event_status_reg.sv */
/*
  One sticky event register with enable-gated summary.
  Assumes set, clear and clear-status come from logic on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none

module event_status_reg #(
  parameter int             W    = 8,
  parameter logic [W-1:0]   USED = '1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_set,
  input  wire logic [W-1:0] i_clear,
  input  wire logic         i_clear_all,
  input  wire logic [W-1:0] i_mask,
  output var  logic [W-1:0] o_bits,
  output var  logic         o_summary
);
  import sbsr_pkg::*;

  logic [W-1:0] bits_r;
  logic [W-1:0] bits_nxt;

  always_comb begin
    // set applied last so a simultaneous read-clear never loses an event
    bits_nxt = (bits_r & ~i_clear & ~{W{i_clear_all}}) | (i_set & USED); // R8 R22
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      bits_r <= '0;
    end else begin
      bits_r <= bits_nxt;
    end
  end

  assign o_bits    = bits_r;
  assign o_summary = |(bits_r & i_mask); // R4 R5

  set_wins_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R22
    i_rst_n |=> ((bits_r & $past(i_set & USED)) == $past(i_set & USED)))
    else $error("event set lost");

  sticky_bits_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R8
    !i_clear_all |=> ((bits_r & $past(bits_r & ~i_clear)) == $past(bits_r & ~i_clear)))
    else $error("event bit dropped without clear");

endmodule : event_status_reg
`default_nettype wire

/* File: design/service_request_edge.sv */
/*
  Service request edge detector and pending flag cleared by serial poll.
  Assumes status and enable are combinational from same-clock registers.
*/
`timescale 1ns/100ps
`default_nettype none
`include "sbsr_map.svh"

module service_request_edge (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire logic [`STB_WIDTH-1:0] i_status,
  input  wire logic [`STB_WIDTH-1:0] i_enable,
  input  wire logic                  i_poll,
  output var  logic                  o_pending,
  output var  logic                  o_enabled_any
);
  import sbsr_pkg::*;

  srq_state_t            st_r;
  srq_state_t            st_nxt;
  logic [`STB_WIDTH-1:0] enabled;
  logic                  rise;

  assign enabled = i_status & i_enable & `STB_REQUEST_MASK;
  assign rise    = |(enabled & ~st_r.prev); // R15 R16

  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = enabled; // R23
    // a new edge in the poll cycle re-arms the request
    st_nxt.pending = rise | (st_r.pending & ~i_poll); // R13 R15
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      st_r <= '{default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_pending     = st_r.pending;
  assign o_enabled_any = |enabled; // R14

  rise_raises_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R15
    rise |=> o_pending)
    else $error("edge without request");

  held_single_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R16
    (!o_pending && !rise) |=> !o_pending)
    else $error("request without edge");

  poll_clears_a: assert property (@(posedge i_clk) disable iff (!i_rst_n) // R13
    (i_poll && !rise) |=> !o_pending)
    else $error("poll left request pending");

endmodule : service_request_edge
`default_nettype wire

/* File: design/status_byte_service_request.sv */
/*
  Status reporting hierarchy: three event registers, enable masks, status
  byte, service request, serial poll and query/read-clear handling.
  Assumes event, level and command strobes come from logic on I_CLK; the
  retained mask inputs hold the masks kept across power loss.
*/
// Contract
// R1: bit 0 high when storage not running
// R2: bit 1 high when no command executing
// R3: bit 4 high while output buffer nonempty
// R4: bits 2,3,5 are masked event summaries
// R5: summary holds until enabled bits cleared
// R6: queue overflows set bits 0/2, flush
// R7: std bits 4,5,6,7 set; 1,3 unused
// R8: std and error bits are sticky
// R9: lockin bits 0,1,3 set; bit 2 unused
// R10: lockin bits 4 to 7 overload, shift
// R11: lockin bits 8 to 11; 12-15 unused
// R12: error bits 1 to 7; bit 0 unused
// R13: poll returns request once, clears it
// R14: status query bit 6 is level OR
// R15: request only on enabled rising bit
// R16: many bits one request; drop re-arms
// R17: host polls devices to find requester
// R18: query clears whole register or one bit
// R19: clear-status zeroes events, keeps masks
// R20: power-on clear selects mask zeroing
// R21: masks written whole or per bit
// R22: set beats simultaneous clear
// R23: summaries and edge update within cycle
`timescale 1ns/100ps
`default_nettype none
`include "sbsr_map.svh"

module status_byte_service_request (
  input  wire logic                       I_CLK,
  input  wire logic                       I_RST_N,
  input  wire logic                       I_POWER_ON_CLEAR,
  input  wire logic [`STB_WIDTH-1:0]      I_KEPT_POLL_ENABLE,
  input  wire logic [`STD_WIDTH-1:0]      I_KEPT_STD_ENABLE,
  input  wire logic [`ERROR_WIDTH-1:0]    I_KEPT_ERROR_ENABLE,
  input  wire logic [`LOCKIN_WIDTH-1:0]   I_KEPT_LOCK_ENABLE,
  input  wire logic                       I_STORAGE_RUNNING,
  input  wire logic                       I_COMMAND_BUSY,
  input  wire logic                       I_OUTPUT_PENDING,
  input  wire logic [`STD_WIDTH-1:0]      I_STD_EVENT,
  input  wire logic [`LOCKIN_WIDTH-1:0]   I_LOCKIN_EVENT,
  input  wire logic [`ERROR_WIDTH-1:0]    I_ERROR_EVENT,
  input  wire logic                       I_CLEAR_STATUS,
  input  wire logic                       I_QUERY,
  input  wire sbsr_pkg::query_sel_t       I_QUERY_SEL,
  input  wire logic                       I_QUERY_BIT,
  input  wire logic [3:0]                 I_QUERY_INDEX,
  input  wire logic                       I_MASK_WRITE,
  input  wire sbsr_pkg::mask_sel_t        I_MASK_SEL,
  input  wire logic                       I_MASK_BIT,
  input  wire logic [3:0]                 I_MASK_INDEX,
  input  wire logic [`QUERY_WIDTH-1:0]    I_MASK_DATA,
  input  wire logic                       I_SERIAL_POLL,
  output var  logic                       O_QUERY_VALID,
  output var  logic [`QUERY_WIDTH-1:0]    O_QUERY_DATA,
  output var  logic                       O_POLL_VALID,
  output var  logic [`STB_WIDTH-1:0]      O_POLL_BYTE,
  output var  logic                       O_SERVICE_REQUEST,
  output var  logic                       O_QUEUE_FLUSH,
  output var  logic [`STB_WIDTH-1:0]      O_STATUS_BYTE,
  output var  logic [`STB_WIDTH-1:0]      O_POLL_ENABLE,
  output var  logic [`STD_WIDTH-1:0]      O_STD_ENABLE,
  output var  logic [`ERROR_WIDTH-1:0]    O_ERROR_ENABLE,
  output var  logic [`LOCKIN_WIDTH-1:0]   O_LOCK_ENABLE,
  output var  logic                       O_READY
);
  import sbsr_pkg::*;

  function automatic logic [15:0] bit_onehot(input logic [3:0] idx);
    bit_onehot = 16'h0001 << idx;
  endfunction : bit_onehot

  function automatic logic [15:0] mask_update(
    input logic [15:0] cur,
    input logic        bit_mode,
    input logic [3:0]  idx,
    input logic [15:0] data
  );
    logic [15:0] oh;
    oh = bit_onehot(idx);
    if (bit_mode) begin
      mask_update = (cur & ~oh) | (oh & {16{data[0]}}); // R21
    end else begin
      mask_update = data; // R21
    end
  endfunction : mask_update

  top_state_t                 st_r;
  top_state_t                 st_nxt;

  logic [`STD_WIDTH-1:0]      std_bits;
  logic [`LOCKIN_WIDTH-1:0]   lock_bits;
  logic [`ERROR_WIDTH-1:0]    err_bits;
  logic                       std_sum;
  logic                       lock_sum;
  logic                       err_sum;
  logic [`STD_WIDTH-1:0]      std_set;
  logic [`STD_WIDTH-1:0]      std_clear;
  logic [`LOCKIN_WIDTH-1:0]   lock_clear;
  logic [`ERROR_WIDTH-1:0]    err_clear;
  logic [`QUERY_WIDTH-1:0]    query_clear;
  logic [`STB_WIDTH-1:0]      stb_now;
  logic [`STB_WIDTH-1:0]      stb_query;
  logic [`STB_WIDTH-1:0]      stb_poll;
  logic                       srq_pending;
  logic                       enabled_any;
  logic                       init;
  logic [`QUERY_WIDTH-1:0]    query_word;

  // first cycle after release captures power-on state
  assign init = !st_r.ready;

  // power-on marker joins the regular standard event inputs
  assign std_set = I_STD_EVENT | ({{(`STD_WIDTH-1){1'b0}}, init} << `STD_POWER_ON); // R7

  // whole read clears all, bit read clears one; other selects clear nothing
  assign query_clear = I_QUERY_BIT ? bit_onehot(I_QUERY_INDEX) : '1; // R18
  assign std_clear   = (I_QUERY && I_QUERY_SEL == Q_STD_EVENT) ? query_clear[`STD_WIDTH-1:0] : '0; // R18
  assign lock_clear  = (I_QUERY && I_QUERY_SEL == Q_LOCKIN) ? query_clear : '0; // R18
  assign err_clear   = (I_QUERY && I_QUERY_SEL == Q_ERROR) ? query_clear[`ERROR_WIDTH-1:0] : '0; // R18

  event_status_reg #(
    .W    (`STD_WIDTH),
    .USED (`STD_USED_MASK)
  ) u_std_event (
    .i_clk       (I_CLK),
    .i_rst_n     (I_RST_N),
    .i_set       (std_set),
    .i_clear     (std_clear),
    .i_clear_all (I_CLEAR_STATUS),
    .i_mask      (st_r.std_en),
    .o_bits      (std_bits),
    .o_summary   (std_sum)
  ); // R6 R7 R8 R19

  event_status_reg #(
    .W    (`LOCKIN_WIDTH),
    .USED (`LOCKIN_USED_MASK)
  ) u_lockin_event (
    .i_clk       (I_CLK),
    .i_rst_n     (I_RST_N),
    .i_set       (I_LOCKIN_EVENT),
    .i_clear     (lock_clear),
    .i_clear_all (I_CLEAR_STATUS),
    .i_mask      (st_r.lock_en),
    .o_bits      (lock_bits),
    .o_summary   (lock_sum)
  ); // R9 R10 R11 R19

  event_status_reg #(
    .W    (`ERROR_WIDTH),
    .USED (`ERROR_USED_MASK)
  ) u_error_event (
    .i_clk       (I_CLK),
    .i_rst_n     (I_RST_N),
    .i_set       (I_ERROR_EVENT),
    .i_clear     (err_clear),
    .i_clear_all (I_CLEAR_STATUS),
    .i_mask      (st_r.err_en),
    .o_bits      (err_bits),
    .o_summary   (err_sum)
  ); // R8 R12 R19

  always_comb begin
    stb_now                        = '0;
    stb_now[`SB_STORAGE_IDLE]      = !I_STORAGE_RUNNING; // R1
    stb_now[`SB_COMMAND_IDLE]      = !I_COMMAND_BUSY; // R2
    stb_now[`SB_ERROR_SUMMARY]     = err_sum; // R4
    stb_now[`SB_LOCKIN_SUMMARY]    = lock_sum; // R4
    stb_now[`SB_MESSAGE_AVAILABLE] = I_OUTPUT_PENDING; // R3
    stb_now[`SB_STD_SUMMARY]       = std_sum; // R4
  end

  // summaries feed the edge detector directly, not through st_r.status
  service_request_edge u_srq (
    .i_clk         (I_CLK),
    .i_rst_n       (I_RST_N),
    .i_status      (stb_now),
    .i_enable      (st_r.poll_en),
    .i_poll        (I_SERIAL_POLL),
    .o_pending     (srq_pending),
    .o_enabled_any (enabled_any)
  ); // R15 R16 R23

  always_comb begin
    stb_query                      = stb_now;
    stb_query[`SB_SERVICE_REQUEST] = enabled_any; // R14
    stb_poll                       = stb_now;
    stb_poll[`SB_SERVICE_REQUEST]  = srq_pending; // R13
  end

  always_comb begin
    query_word = '0;
    unique case (I_QUERY_SEL)
      Q_STATUS_BYTE:  query_word[`STB_WIDTH-1:0]    = stb_query; // R14
      Q_STD_EVENT:    query_word[`STD_WIDTH-1:0]    = std_bits;
      Q_LOCKIN:       query_word                    = lock_bits;
      Q_ERROR:        query_word[`ERROR_WIDTH-1:0]  = err_bits;
      Q_POLL_ENABLE:  query_word[`STB_WIDTH-1:0]    = st_r.poll_en;
      Q_STD_ENABLE:   query_word[`STD_WIDTH-1:0]    = st_r.std_en;
      Q_ERROR_ENABLE: query_word[`ERROR_WIDTH-1:0]  = st_r.err_en;
      Q_LOCK_ENABLE:  query_word                    = st_r.lock_en;
    endcase
  end

  always_comb begin
    st_nxt             = st_r;
    st_nxt.ready       = 1'b1;
    st_nxt.query_valid = I_QUERY;
    st_nxt.poll_valid  = I_SERIAL_POLL;
    st_nxt.status      = stb_query;
    // overflow of either queue empties both queues
    st_nxt.flush = I_STD_EVENT[`STD_INPUT_QUEUE_OVERFLOW] | I_STD_EVENT[`STD_OUTPUT_QUEUE_OVERFLOW]; // R6
    if (I_QUERY) begin
      if (I_QUERY_BIT) begin
        st_nxt.query_data = {{(`QUERY_WIDTH-1){1'b0}}, query_word[I_QUERY_INDEX]}; // R18
      end else begin
        st_nxt.query_data = query_word; // R18
      end
    end
    if (I_SERIAL_POLL) begin
      st_nxt.poll_byte = stb_poll; // R13
    end
    // masks are not touched by clear-status, only by writes and power-on
    if (init) begin
      if (!I_POWER_ON_CLEAR) begin
        st_nxt.poll_en = I_KEPT_POLL_ENABLE; // R20
        st_nxt.std_en  = I_KEPT_STD_ENABLE; // R20
        st_nxt.err_en  = I_KEPT_ERROR_ENABLE; // R20
        st_nxt.lock_en = I_KEPT_LOCK_ENABLE; // R20
      end
    end else if (I_MASK_WRITE) begin
      unique case (I_MASK_SEL)
        M_POLL_ENABLE: begin
          st_nxt.poll_en = 8'(mask_update({8'h00, st_r.poll_en}, I_MASK_BIT, I_MASK_INDEX, I_MASK_DATA)); // R21
        end
        M_STD_ENABLE: begin
          st_nxt.std_en = 8'(mask_update({8'h00, st_r.std_en}, I_MASK_BIT, I_MASK_INDEX, I_MASK_DATA)); // R21
        end
        M_ERROR_ENABLE: begin
          st_nxt.err_en = 8'(mask_update({8'h00, st_r.err_en}, I_MASK_BIT, I_MASK_INDEX, I_MASK_DATA)); // R21
        end
        M_LOCK_ENABLE: begin
          st_nxt.lock_en = mask_update(st_r.lock_en, I_MASK_BIT, I_MASK_INDEX, I_MASK_DATA); // R21
        end
      endcase
    end
  end

  // all-zero reset doubles as power-on clear of every mask
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      st_r <= '{default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign O_QUERY_VALID     = st_r.query_valid;
  assign O_QUERY_DATA      = st_r.query_data;
  assign O_POLL_VALID      = st_r.poll_valid;
  assign O_POLL_BYTE       = st_r.poll_byte;
  assign O_SERVICE_REQUEST = srq_pending;
  assign O_QUEUE_FLUSH     = st_r.flush;
  assign O_STATUS_BYTE     = st_r.status;
  assign O_POLL_ENABLE     = st_r.poll_en;
  assign O_STD_ENABLE      = st_r.std_en;
  assign O_ERROR_ENABLE    = st_r.err_en;
  assign O_LOCK_ENABLE     = st_r.lock_en;
  assign O_READY           = st_r.ready;

  storage_idle_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R1
    $past(I_RST_N) |-> O_STATUS_BYTE[`SB_STORAGE_IDLE] == !$past(I_STORAGE_RUNNING))
    else $error("storage idle bit wrong");

  command_idle_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R2
    $past(I_RST_N) |-> O_STATUS_BYTE[`SB_COMMAND_IDLE] == !$past(I_COMMAND_BUSY))
    else $error("command idle bit wrong");

  output_pending_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R3
    $past(I_RST_N) |-> O_STATUS_BYTE[`SB_MESSAGE_AVAILABLE] == $past(I_OUTPUT_PENDING))
    else $error("message bit wrong");

  std_summary_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R4
    $past(I_RST_N) |-> O_STATUS_BYTE[`SB_STD_SUMMARY] == $past(|(std_bits & st_r.std_en)))
    else $error("standard summary wrong");

  lockin_summary_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R4
    $past(I_RST_N) |-> O_STATUS_BYTE[`SB_LOCKIN_SUMMARY] == $past(|(lock_bits & st_r.lock_en)))
    else $error("lockin summary wrong");

  error_summary_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R4
    $past(I_RST_N) |-> O_STATUS_BYTE[`SB_ERROR_SUMMARY] == $past(|(err_bits & st_r.err_en)))
    else $error("error summary wrong");

  overflow_flush_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R6
    I_STD_EVENT[`STD_OUTPUT_QUEUE_OVERFLOW] |=> O_QUEUE_FLUSH ##1 std_bits[`STD_OUTPUT_QUEUE_OVERFLOW] || !I_RST_N)
    else $error("overflow not flushed");

  input_flush_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R6
    I_STD_EVENT[`STD_INPUT_QUEUE_OVERFLOW] |=> O_QUEUE_FLUSH && std_bits[`STD_INPUT_QUEUE_OVERFLOW])
    else $error("input overflow not flushed");

  power_on_bit_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R7
    (I_RST_N && init) |=> std_bits[`STD_POWER_ON])
    else $error("power-on bit missing");

  poll_answer_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R13
    I_SERIAL_POLL |=> O_POLL_VALID && O_POLL_BYTE[`SB_SERVICE_REQUEST] == $past(srq_pending))
    else $error("poll byte wrong");

  query_level_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R14
    (I_QUERY && I_QUERY_SEL == Q_STATUS_BYTE && !I_QUERY_BIT)
      |=> O_QUERY_DATA[`SB_SERVICE_REQUEST] == $past(enabled_any)
          && (srq_pending || !$past(srq_pending) || $past(I_SERIAL_POLL)))
    else $error("status query bit 6 wrong");

  whole_clear_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R18
    (I_QUERY && I_QUERY_SEL == Q_ERROR && !I_QUERY_BIT && I_ERROR_EVENT == 8'h00)
      |=> O_QUERY_VALID && err_bits == 8'h00 && O_QUERY_DATA[7:0] == $past(err_bits))
    else $error("error register not read-cleared");

  clear_keeps_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R19
    (I_CLEAR_STATUS && !I_MASK_WRITE && !init && I_LOCKIN_EVENT == 16'h0000)
      |=> lock_bits == 16'h0000 && $stable(st_r.lock_en) && $stable(st_r.poll_en))
    else $error("clear-status wrong");

  kept_masks_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R20
    (I_RST_N && init && !I_POWER_ON_CLEAR) |=> O_LOCK_ENABLE == $past(I_KEPT_LOCK_ENABLE))
    else $error("kept mask not restored");

  mask_bit_a: assert property (@(posedge I_CLK) disable iff (!I_RST_N) // R21
    (!init && I_MASK_WRITE && I_MASK_SEL == M_LOCK_ENABLE && I_MASK_BIT)
      |=> O_LOCK_ENABLE[$past(I_MASK_INDEX)] == $past(I_MASK_DATA[0]))
    else $error("mask bit write wrong");

endmodule : status_byte_service_request
`default_nettype wire

/* File: sim/host_ctl.sv */
/* Host controller model: register queries and serial polls.
   Assumes the bench calls one task at a time, on the block's clock. */
`timescale 1ns/100ps
`default_nettype none
module host_ctl (
  input  wire logic                 i_clk,
  input  wire logic                 i_q_valid,
  input  wire logic [15:0]          i_q_data,
  input  wire logic                 i_p_valid,
  input  wire logic [7:0]           i_p_byte,
  output var  logic                 o_query,
  output var  sbsr_pkg::query_sel_t o_sel,
  output var  logic                 o_bit,
  output var  logic [3:0]           o_idx,
  output var  logic                 o_poll
);
  import sbsr_pkg::*;
  int tmo = 0;
  initial begin
    o_query = 1'b0;
    o_sel   = Q_STATUS_BYTE;
    o_bit   = 1'b0;
    o_idx   = 4'h0;
    o_poll  = 1'b0;
  end
  task automatic query(input query_sel_t s, input logic b, input logic [3:0] x, output logic [15:0] d);
    int n;
    @(posedge i_clk);
    o_query <= 1'b1;
    o_sel   <= s;
    o_bit   <= b;
    o_idx   <= x;
    @(posedge i_clk);
    o_query <= 1'b0;
    #1;
    for (n = 0; n < 4 && i_q_valid !== 1'b1; n++) @(posedge i_clk) #1;
    if (n == 4) tmo++;
    d = i_q_data;
  endtask : query
  // a poll is how the host finds who raised the request
  task automatic poll(output logic [7:0] p);
    int n;
    @(posedge i_clk);
    o_poll <= 1'b1;
    @(posedge i_clk);
    o_poll <= 1'b0;
    #1;
    for (n = 0; n < 4 && i_p_valid !== 1'b1; n++) @(posedge i_clk) #1;
    if (n == 4) tmo++;
    p = i_p_byte;
  endtask : poll
endmodule : host_ctl
`default_nettype wire

/* File: sim/tb_top.sv */
/* Self-checking bench of the status reporting block against a scoreboard.
   Assumes host_ctl and the design sources are compiled before it. */
`timescale 1ns/100ps
`default_nettype none
`include "sbsr_map.svh"
module tb_top;
  import sbsr_pkg::*;
  logic        clk, rst_n, poc, run, busy, pend, cls, mw, mbit, qv, pv, srq, flush, rdy, qry, qbit, spoll;
  logic [3:0]  midx, qidx;
  logic [7:0]  kp, ks, ke, std_ev, err_ev, pb, stb, ope, ose, oee, b;
  logic [15:0] kl, lock_ev, mdata, qd, ole, d;
  logic [15:0] om [4];
  query_sel_t  qsel;
  mask_sel_t   msel;
  int          fails, check_count, ev_m[3], msk[4];
  int          wd[4] = '{8, 8, 8, 16};
  status_byte_service_request u_dut (
    .I_CLK(clk), .I_RST_N(rst_n), .I_POWER_ON_CLEAR(poc), .I_KEPT_POLL_ENABLE(kp),
    .I_KEPT_STD_ENABLE(ks), .I_KEPT_ERROR_ENABLE(ke), .I_KEPT_LOCK_ENABLE(kl),
    .I_STORAGE_RUNNING(run), .I_COMMAND_BUSY(busy), .I_OUTPUT_PENDING(pend),
    .I_STD_EVENT(std_ev), .I_LOCKIN_EVENT(lock_ev), .I_ERROR_EVENT(err_ev), .I_CLEAR_STATUS(cls),
    .I_QUERY(qry), .I_QUERY_SEL(qsel), .I_QUERY_BIT(qbit), .I_QUERY_INDEX(qidx),
    .I_MASK_WRITE(mw), .I_MASK_SEL(msel), .I_MASK_BIT(mbit), .I_MASK_INDEX(midx), .I_MASK_DATA(mdata),
    .I_SERIAL_POLL(spoll), .O_QUERY_VALID(qv), .O_QUERY_DATA(qd), .O_POLL_VALID(pv), .O_POLL_BYTE(pb),
    .O_SERVICE_REQUEST(srq), .O_QUEUE_FLUSH(flush), .O_STATUS_BYTE(stb), .O_POLL_ENABLE(ope),
    .O_STD_ENABLE(ose), .O_ERROR_ENABLE(oee), .O_LOCK_ENABLE(ole), .O_READY(rdy));
  host_ctl u_host (.i_clk(clk), .i_q_valid(qv), .i_q_data(qd), .i_p_valid(pv), .i_p_byte(pb),
    .o_query(qry), .o_sel(qsel), .o_bit(qbit), .o_idx(qidx), .o_poll(spoll));
  always_comb om = '{16'(ope), 16'(ose), 16'(oee), ole};
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic end_of_test();
    fails += u_host.tmo;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  function automatic int stb_e();
    int v;
    v = int'(!run) | int'(!busy) << 1 | int'(pend) << 4;
    v |= int'((ev_m[2] & msk[2]) != 0) << 2 | int'((ev_m[1] & msk[3]) != 0) << 3;
    v |= int'((ev_m[0] & msk[1]) != 0) << 5;
    return v | int'((v & msk[0] & 'h3F) != 0) << 6;
  endfunction : stb_e
  task automatic ev(input logic [7:0] s, input logic [15:0] l, input logic [7:0] e);
    @(posedge clk);
    std_ev  <= s;
    lock_ev <= l;
    err_ev  <= e;
    @(posedge clk);
    std_ev  <= '0;
    lock_ev <= '0;
    err_ev  <= '0;
    ev_m[0] |= s & `STD_USED_MASK;
    ev_m[1] |= l & `LOCKIN_USED_MASK;
    ev_m[2] |= e & `ERROR_USED_MASK;
    #1;
    chk("flush", 16'(s[0] | s[2]), 16'(flush));
  endtask : ev
  // snapshot before the host call, so a set landing with the read survives
  task automatic rd(input int q, input logic bm, input int x);
    int e;
    e = (q == 0) ? stb_e() : (q < 4) ? ev_m[q-1] : msk[q-4];
    e = bm ? (e >> x) & 1 : e;
    if (q inside {[1:3]}) ev_m[q-1] &= bm ? ~(1 << x) : 0;
    u_host.query(query_sel_t'(q), bm, 4'(x), d);
    if (u_host.tmo > 0) end_of_test();
    chk("query", 16'(e), d);
  endtask : rd
  task automatic pl(input logic e6);
    int v;
    v = stb_e();
    u_host.poll(b);
    if (u_host.tmo > 0) end_of_test();
    chk("poll request", 16'(e6), 16'(b[6]));
    chk("poll status", 16'(v & 'h3F), 16'(b & 8'h3F));
    chk("request after poll", 16'h0, 16'(srq));
  endtask : pl
  task automatic wr(input int s, input logic bm, input int x, input logic [15:0] v);
    @(posedge clk);
    mw    <= 1'b1;
    msel  <= mask_sel_t'(s);
    mbit  <= bm;
    midx  <= 4'(x);
    mdata <= v;
    @(posedge clk);
    mw <= 1'b0;
    if (!bm) msk[s] = v & ((1 << wd[s]) - 1);
    else if (x < wd[s]) msk[s][x] = v[0];
    #1;
    chk("mask", 16'(msk[s]), om[s]);
  endtask : wr
  task automatic rq(input logic [15:0] l, input logic e);
    ev(8'h00, l, 8'h00);
    @(posedge clk);
    #1;
    chk("request", 16'(e), 16'(srq));
  endtask : rq
  task automatic rst(input logic c);
    @(posedge clk);
    rst_n <= 1'b0;
    poc   <= c;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    msk  = c ? '{0, 0, 0, 0} : '{int'(kp), int'(ks), int'(ke), int'(kl)};
    ev_m = '{'h80, 0, 0};
    repeat (3) @(posedge clk);
    #1;
    chk("ready", 16'h1, 16'(rdy));
  endtask : rst
  initial begin
    void'($urandom(32'h87E13C38));
    {rst_n, poc, run, busy, pend, cls, mw, mbit, midx, mdata, std_ev, lock_ev, err_ev} = '0;
    msel = M_POLL_ENABLE;
    {kp, ks, ke, kl} = {8'($urandom), 8'($urandom), 8'($urandom), 16'($urandom)};
    rst(1'b0);
    pl(1'(stb_e() >> 6));
    for (int q = 1; q < 8; q++) rd(q, 1'b0, 0);
    $display("reset test done");
    repeat (40) begin
      wr($urandom % 4, 1'($urandom), $urandom % 16, 16'($urandom));
      ev(8'($urandom), 16'($urandom), 8'($urandom));
      @(posedge clk);
      run  <= 1'($urandom);
      busy <= 1'($urandom);
      pend <= 1'($urandom);
      repeat (3) @(posedge clk);
      #1;
      chk("status byte", 16'(stb_e()), 16'(stb));
      rd(0, 1'($urandom), $urandom % 8);
      rd(1 + $urandom % 7, 1'($urandom), $urandom % 16);
    end
    $display("random test done");
    @(posedge clk);
    cls <= 1'b1;
    @(posedge clk);
    cls  <= 1'b0;
    ev_m = '{0, 0, 0};
    for (int q = 1; q < 8; q++) rd(q, 1'b0, 0);
    $display("clear test done");
    wr(0, 1'b0, 0, 16'h0008);
    wr(3, 1'b0, 0, 16'h0030);
    u_host.poll(b);
    rq(16'h0030, 1'b1);
    pl(1'b1);
    pl(1'b0);
    rd(2, 1'b1, 4);
    rq(16'h0010, 1'b0);
    rd(2, 1'b0, 0);
    rq(16'h0020, 1'b1);
    rd(0, 1'b0, 0);
    fork
      rd(2, 1'b0, 0);
      ev(8'h00, 16'h0010, 8'h00);
    join
    rd(2, 1'b0, 0);
    $display("request test done");
    rst(1'b1);
    for (int q = 1; q < 8; q++) rd(q, 1'b0, 0);
    $display("power-on clear test done");
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
